// ==== ebcps_pkg.sv ====
// Constants, layouts and state codes of the external bus cycle sequencer.
// Assumes one 100 MHz system clock and a plain word register port.
// How it works
// - Cycle runs up to five phases in fixed order; zero-length ones are skipped
// - Each phase length programmable per chip select
// - Address setup 1..2, plus 0..3 on change
// - Command 0..3, setup/turnaround 0..1, hold 0..3
// - Access 1..32, ready input may stretch it
// - Read data and ready taken at strobe end
// - Late address change cannot spoil read data
// - Reference clock output is the system clock
// - Shared or separate address and data lines
// - Ready polarity selectable, synchronous sampling supported
// - Asynchronous ready synchronised, adds four waits
// - Inactive ready inserts wait, active ends access
package ebcps_pkg;

	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int BUS_AW    = 24;
	localparam int BUS_DW    = 16;
	localparam int LEN_W     = 6;
	localparam int WAIT_W    = 8;

	// Register byte offsets
	localparam logic [7:0] OFS_CFG0   = 8'h00;
	localparam logic [7:0] OFS_CFG1   = 8'h04;
	localparam logic [7:0] OFS_ADDR   = 8'h08;
	localparam logic [7:0] OFS_WDATA  = 8'h0C;
	localparam logic [7:0] OFS_CMD    = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_RDATA  = 8'h18;

	// Command register fields
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_CS_BIT    = 1;
	localparam int CMD_UBO_BIT   = 2;
	localparam int CMD_W         = 3;

	// Status register fields
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_DONE_BIT   = 1;
	localparam int ST_WAIT_LSB   = 8;

	// Reset values
	localparam int CFG_W = 17;
	localparam logic [CFG_W-1:0] CFG_RST = 17'h00040;

	// One chip_select_timing_config word; lengths in system clock periods
	typedef struct packed {
		logic       ready_async; // Ready through the synchroniser
		logic       ready_pol;   // 1: ready active high
		logic       ready_en;    // Access phase may be stretched
		logic       shared_mode; // 1: shared address/data lines
		logic [1:0] hold_len;
		logic [4:0] access_len;  // Periods minus one
		logic       write_setup_turnaround_len;
		logic [1:0] command_delay_len;
		logic [1:0] addr_ext_len;
		logic       address_setup_len; // Periods minus one
	} ebcps_cfg_s;

	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_AB   = 3'h1,
		PH_C    = 3'h2,
		PH_D    = 3'h3,
		PH_E    = 3'h4,
		PH_F    = 3'h5
	} ebcps_phase_e;

endpackage : ebcps_pkg

// ==== ebcps_sync3.sv ====
// Three-stage synchroniser for an input from outside the clock domain.
// Assumes a clean synchronous reset copy from the top module.
`timescale 1ns/1ps
module ebcps_sync3
(
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_async,
	output logic      o_level
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	// First stage feeds only the second; output moves once stages agree
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			o_level <= 1'b0;
		end
		else
		begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				o_level <= s3_q;
		end
	end

endmodule : ebcps_sync3

// ==== ebcps_seq.sv ====
// External bus cycle phase sequencer with its register port and pins.
// Assumes a register master on i_clk; bus pins resolved by the testbench.
`timescale 1ns/1ps
module ebcps_seq
#(
	parameter int NCS = 2
)
(
	input  wire logic                         i_clk,
	input  wire logic                         i_nrst,
	input  wire logic [ebcps_pkg::ADDR_W-1:0] i_reg_addr,
	input  wire logic [ebcps_pkg::DATA_W-1:0] i_reg_wdata,
	input  wire logic                         i_reg_wr,
	input  wire logic                         i_reg_rd,
	output logic      [ebcps_pkg::DATA_W-1:0] o_reg_rdata,
	output wire logic                         o_bus_ref_clk,
	output logic                              o_clk_hs_en,
	output logic      [ebcps_pkg::BUS_AW-1:0] o_addr,
	output logic      [ebcps_pkg::BUS_DW-1:0] o_ad,
	output logic                              o_ad_oe,
	input  wire logic [ebcps_pkg::BUS_DW-1:0] i_ad,
	output logic                              o_ale,
	output logic                              o_rd_n,
	output logic                              o_wr_n,
	output logic                              o_upper_byte_enable_n,
	output logic      [NCS-1:0]               o_cs_n,
	input  wire logic                         i_ready
);

	localparam int CSW    = (NCS > 1) ? $clog2(NCS) : 1;
	localparam int DATA_W = ebcps_pkg::DATA_W;
	localparam int LEN_W  = ebcps_pkg::LEN_W;

	logic                                rst_meta_q;
	logic                                rst_n;
	logic                                rdy_sync;
	ebcps_pkg::ebcps_cfg_s [NCS-1:0]     cfg_q;
	logic [ebcps_pkg::BUS_AW-1:0]        addr_q;
	logic [ebcps_pkg::BUS_DW-1:0]        wdata_q;
	logic [ebcps_pkg::CMD_W-1:0]         cmd_q;
	ebcps_pkg::ebcps_phase_e             state_q;
	ebcps_pkg::ebcps_phase_e             state_d;
	logic [ebcps_pkg::LEN_W-1:0]         cnt_q;
	logic [ebcps_pkg::LEN_W-1:0]         cnt_d;
	ebcps_pkg::ebcps_cfg_s               cur_q;
	ebcps_pkg::ebcps_cfg_s               cur_d;
	logic [CSW-1:0]                      cs_q;
	logic [CSW-1:0]                      cs_d;
	logic [CSW-1:0]                      last_cs_q;
	logic                                have_last_q;
	logic                                ext_q;
	logic                                ext_d;
	logic                                wr_q;
	logic                                wr_d;
	logic                                ubo_d;
	logic                                async_wait_q;
	logic                                async_wait_d;
	logic                                done_q;
	logic [ebcps_pkg::WAIT_W-1:0]        waits_q;
	logic [ebcps_pkg::BUS_DW-1:0]        rdata_q;
	logic                                start;
	logic                                rdy_active;
	logic                                stretch;
	logic                                finish;

	// Length of one phase in periods for a given configuration
	function automatic logic [ebcps_pkg::LEN_W-1:0] phase_len
	(
		input ebcps_pkg::ebcps_phase_e ph,
		input ebcps_pkg::ebcps_cfg_s   c,
		input logic                    ext
	);
		logic [ebcps_pkg::LEN_W-1:0] len;
		len = '0;
		unique case (ph)
			ebcps_pkg::PH_AB:
				len = LEN_W'(c.address_setup_len) + 6'h01
					+ (ext ? LEN_W'(c.addr_ext_len) : 6'h00);
			ebcps_pkg::PH_C: len = LEN_W'(c.command_delay_len);
			ebcps_pkg::PH_D: len = LEN_W'(c.write_setup_turnaround_len);
			ebcps_pkg::PH_E: len = LEN_W'(c.access_len) + 6'h01;
			ebcps_pkg::PH_F: len = LEN_W'(c.hold_len);
			default:         len = '0;
		endcase
		return len;
	endfunction : phase_len

	// First phase after ph with a nonzero length, else idle
	function automatic ebcps_pkg::ebcps_phase_e next_phase
	(
		input ebcps_pkg::ebcps_phase_e ph,
		input ebcps_pkg::ebcps_cfg_s   c,
		input logic                    ext
	);
		ebcps_pkg::ebcps_phase_e res;
		ebcps_pkg::ebcps_phase_e p;
		res = ebcps_pkg::PH_IDLE;
		for (int i = 5; i >= 1; i--)
		begin
			p = ebcps_pkg::ebcps_phase_e'(3'(i));
			if (p > ph && phase_len(p, c, ext) != '0)
				res = p;
		end
		return res;
	endfunction : next_phase

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Forwarded system clock; the pad needs its fast driver
	assign o_bus_ref_clk = i_clk;

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			o_clk_hs_en <= 1'b0;
		else
			o_clk_hs_en <= 1'b1;
	end

	ebcps_sync3 u_rdy_sync
	(
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_async (i_ready),
		.o_level (rdy_sync)
	);

	// Synchronous mode looks at the pin straight on the edge
	assign rdy_active = (cur_q.ready_async ? rdy_sync : i_ready)
		== cur_q.ready_pol;

	assign start = i_reg_wr && (i_reg_addr == ebcps_pkg::OFS_CMD)
		&& (state_q == ebcps_pkg::PH_IDLE);

	// Software registers; writes to the command word while busy are dropped
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_q   <= {NCS{ebcps_pkg::CFG_RST}};
			addr_q  <= '0;
			wdata_q <= '0;
			cmd_q   <= '0;
		end
		else if (i_reg_wr)
		begin
			unique case (i_reg_addr)
				ebcps_pkg::OFS_CFG0:
					cfg_q[0] <= i_reg_wdata[ebcps_pkg::CFG_W-1:0];
				ebcps_pkg::OFS_CFG1:
					cfg_q[NCS-1] <= i_reg_wdata[ebcps_pkg::CFG_W-1:0];
				ebcps_pkg::OFS_ADDR:
					addr_q <= i_reg_wdata[ebcps_pkg::BUS_AW-1:0];
				ebcps_pkg::OFS_WDATA:
					wdata_q <= i_reg_wdata[ebcps_pkg::BUS_DW-1:0];
				ebcps_pkg::OFS_CMD:
					if (state_q == ebcps_pkg::PH_IDLE)
						cmd_q <= i_reg_wdata[ebcps_pkg::CMD_W-1:0];
				default:
					cmd_q <= cmd_q;
			endcase
		end
	end

	// Cycle parameters as they will stand in the next cycle
	always_comb
	begin
		cs_d  = start ? CSW'(i_reg_wdata[ebcps_pkg::CMD_CS_BIT]) : cs_q;
		wr_d  = start ? i_reg_wdata[ebcps_pkg::CMD_WRITE_BIT] : wr_q;
		ubo_d = start ? i_reg_wdata[ebcps_pkg::CMD_UBO_BIT]
			: cmd_q[ebcps_pkg::CMD_UBO_BIT];
		cur_d = start ? cfg_q[cs_d] : cur_q;
		ext_d = start ? (!have_last_q || last_cs_q != cs_d) : ext_q;
	end

	// Phase sequencer: AB, C, D, E, F, each counted down from its length
	always_comb
	begin
		state_d      = state_q;
		cnt_d        = cnt_q;
		async_wait_d = async_wait_q;
		stretch      = 1'b0;
		finish       = 1'b0;
		unique case (state_q)
			ebcps_pkg::PH_IDLE:
				if (start)
				begin
					state_d = ebcps_pkg::PH_AB;
					cnt_d   = phase_len(ebcps_pkg::PH_AB, cur_d, ext_d)
						- 6'h01;
				end
			ebcps_pkg::PH_E:
				if (cnt_q != '0)
					cnt_d = cnt_q - 6'h01;
				else if (!cur_q.ready_en)
					finish = 1'b1;
				else if (cur_q.ready_async && !async_wait_q)
				begin
					async_wait_d = 1'b1;
					stretch      = 1'b1;
				end
				else if (rdy_active)
					finish = 1'b1;
				else
					stretch = 1'b1;
			default:
				if (cnt_q != '0)
					cnt_d = cnt_q - 6'h01;
				else
					finish = 1'b1;
		endcase
		if (finish)
		begin
			state_d      = next_phase(state_q, cur_q, ext_q);
			cnt_d        = phase_len(state_d, cur_q, ext_q) - 6'h01;
			async_wait_d = 1'b0;
		end
	end

	// Sequencer state and per-cycle parameters
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q      <= ebcps_pkg::PH_IDLE;
			cnt_q        <= '0;
			cur_q        <= ebcps_pkg::CFG_RST;
			cs_q         <= '0;
			wr_q         <= 1'b0;
			ext_q        <= 1'b0;
			async_wait_q <= 1'b0;
			last_cs_q    <= '0;
			have_last_q  <= 1'b0;
		end
		else
		begin
			state_q      <= state_d;
			cnt_q        <= cnt_d;
			cur_q        <= cur_d;
			cs_q         <= cs_d;
			wr_q         <= wr_d;
			ext_q        <= ext_d;
			async_wait_q <= async_wait_d;
			if (start)
			begin
				last_cs_q   <= cs_d;
				have_last_q <= 1'b1;
			end
		end
	end

	// Read data latched on the edge that lifts the read strobe; the pins
	// may change after it, and a later address move cannot reach it
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= '0;
		else if (state_q == ebcps_pkg::PH_E && finish && !wr_q)
			rdata_q <= i_ad;
	end

	// Done is sticky; a cycle ending beats a clear in the same cycle
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			done_q  <= 1'b0;
			waits_q <= '0;
		end
		else
		begin
			if (start)
				waits_q <= '0;
			else if (stretch && waits_q != '1)
				waits_q <= waits_q + 8'h01;
			if (state_q != ebcps_pkg::PH_IDLE
				&& state_d == ebcps_pkg::PH_IDLE)
				done_q <= 1'b1;
			else if (i_reg_wr && i_reg_addr == ebcps_pkg::OFS_STATUS
				&& i_reg_wdata[ebcps_pkg::ST_DONE_BIT])
				done_q <= 1'b0;
		end
	end

	// Pins registered from the next phase so they change on the edge
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_addr                <= '0;
			o_ad                  <= '0;
			o_ad_oe               <= 1'b0;
			o_ale                 <= 1'b0;
			o_rd_n                <= 1'b1;
			o_wr_n                <= 1'b1;
			o_upper_byte_enable_n <= 1'b1;
			o_cs_n                <= '1;
		end
		else
		begin
			o_ale  <= (state_d == ebcps_pkg::PH_AB);
			o_rd_n <= !(state_d == ebcps_pkg::PH_E && !wr_d);
			o_wr_n <= !(state_d == ebcps_pkg::PH_E && wr_d);
			o_cs_n <= '1;
			if (state_d != ebcps_pkg::PH_IDLE)
			begin
				o_cs_n[cs_d]          <= 1'b0;
				o_addr                <= addr_q;
				o_upper_byte_enable_n <= ubo_d;
			end
			// Shared lines carry the address in setup, then data
			if (cur_d.shared_mode && state_d == ebcps_pkg::PH_AB)
			begin
				o_ad    <= addr_q[ebcps_pkg::BUS_DW-1:0];
				o_ad_oe <= 1'b1;
			end
			else if (wr_d && state_d >= ebcps_pkg::PH_C
				&& !(cur_d.shared_mode && state_d == ebcps_pkg::PH_C))
			begin
				o_ad    <= wdata_q;
				o_ad_oe <= 1'b1;
			end
			else
				o_ad_oe <= 1'b0;
		end
	end

	// Register read data, valid in the cycle after the strobe only
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			o_reg_rdata <= '0;
		else if (!i_reg_rd)
			o_reg_rdata <= '0;
		else
		begin
			unique case (i_reg_addr)
				ebcps_pkg::OFS_CFG0:
					o_reg_rdata <= DATA_W'(cfg_q[0]);
				ebcps_pkg::OFS_CFG1:
					o_reg_rdata <= DATA_W'(cfg_q[NCS-1]);
				ebcps_pkg::OFS_ADDR:   o_reg_rdata <= DATA_W'(addr_q);
				ebcps_pkg::OFS_WDATA:  o_reg_rdata <= DATA_W'(wdata_q);
				ebcps_pkg::OFS_CMD:    o_reg_rdata <= DATA_W'(cmd_q);
				ebcps_pkg::OFS_STATUS:
					o_reg_rdata <= DATA_W'({waits_q, 6'h00, done_q,
						state_q != ebcps_pkg::PH_IDLE});
				ebcps_pkg::OFS_RDATA:  o_reg_rdata <= DATA_W'(rdata_q);
				default:               o_reg_rdata <= '0;
			endcase
		end
	end

endmodule : ebcps_seq

// ==== ebcps_checker.sv ====
// Pin checker for the external bus cycle sequencer.
// Assumes it is bound onto ebcps_seq and sees only its ports.
`timescale 1ns/1ps
module ebcps_checker
#(
	parameter int NCS = 2
)
(
	input wire logic           i_clk,
	input wire logic           i_nrst,
	input wire logic [7:0]     i_reg_addr,
	input wire logic [31:0]    i_reg_wdata,
	input wire logic           i_reg_wr,
	input wire logic           i_reg_rd,
	input wire logic [31:0]    o_reg_rdata,
	input wire logic           o_bus_ref_clk,
	input wire logic           o_clk_hs_en,
	input wire logic [23:0]    o_addr,
	input wire logic [15:0]    o_ad,
	input wire logic           o_ad_oe,
	input wire logic [15:0]    i_ad,
	input wire logic           o_ale,
	input wire logic           o_rd_n,
	input wire logic           o_wr_n,
	input wire logic           o_upper_byte_enable_n,
	input wire logic [NCS-1:0] o_cs_n,
	input wire logic           i_ready
);
	default clocking dcb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// Some chip select is active
	wire sel = ~&o_cs_n;
	wire strobe = !(o_rd_n && o_wr_n);

	property p_ref_clk; o_bus_ref_clk == i_clk; endproperty
	a_ref_clk: assert property (p_ref_clk)
		else $error("reference clock differs");
	property p_one_strobe; o_rd_n || o_wr_n; endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("both strobes low");
	property p_ale_first; o_ale |-> !strobe && sel; endproperty
	a_ale_first: assert property (p_ale_first)
		else $error("strobe during address setup");
	property p_strobe_sel; strobe |-> sel; endproperty
	a_strobe_sel: assert property (p_strobe_sel)
		else $error("strobe without chip select");
	// Longest setup is two periods plus three for a window change
	property p_setup_len; o_ale |-> ##[1:5] !o_ale; endproperty
	a_setup_len: assert property (p_setup_len)
		else $error("address setup too long");
	property p_cmd_delay; $fell(o_ale) |-> ##[0:4] strobe; endproperty
	a_cmd_delay: assert property (p_cmd_delay)
		else $error("command delay too long");
	property p_shared; o_ale && o_ad_oe |-> o_ad == o_addr[15:0]; endproperty
	a_shared: assert property (p_shared)
		else $error("shared lines lack address");
	property p_rd_float; !o_rd_n |-> !o_ad_oe; endproperty
	a_rd_float: assert property (p_rd_float)
		else $error("data driven during read");
	property p_wr_hold;
		!o_wr_n && !$past(o_wr_n) |-> o_ad_oe && $stable(o_ad)
			&& $stable(o_addr);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write data moved under strobe");
	c_read: cover property ($rose(o_rd_n));
	c_write: cover property ($rose(o_wr_n));
	c_shared: cover property (o_ale && o_ad_oe);
endmodule : ebcps_checker

bind ebcps_seq ebcps_checker #(.NCS(NCS)) ebcps_checker_i (.*);

// ==== ebcps_mem_model.sv ====
// Memory or peripheral model on the external parallel bus.
// Assumes address on o_addr low bits in both modes.
`timescale 1ns/1ps
module ebcps_mem_model
(
	input  wire logic        i_clk,
	input  wire logic        i_sel,
	input  wire logic [3:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wdata_oe,
	input  wire logic        i_rd_n,
	input  wire logic        i_wr_n,
	input  wire logic        i_pol,
	input  wire logic [3:0]  i_wait,
	output logic      [15:0] o_rdata,
	output logic             o_ready
);
	logic [15:0] mem_q [16];
	logic [15:0] last_q = 16'h0000;
	logic [3:0]  cnt_q = 4'h0;
	wire rd = i_sel && !i_rd_n;
	wire strobe = i_sel && !(i_rd_n && i_wr_n);
	// Released data show the inverse so a late capture cannot pass
	assign o_rdata = rd ? mem_q[i_addr] : ~last_q;
	// Ready after i_wait strobe cycles, dropped with the strobe
	assign o_ready = (strobe && cnt_q >= i_wait) ? i_pol : !i_pol;
	// Strobe age saturates so long accesses keep ready up
	always_ff @(posedge i_clk)
	begin
		last_q <= o_rdata;
		cnt_q <= strobe ? cnt_q + 4'(cnt_q != 4'hF) : 4'h0;
		if (strobe && !i_wr_n && i_wdata_oe)
			mem_q[i_addr] <= i_wdata;
	end
endmodule : ebcps_mem_model

// ==== tb_top.sv ====
// Self-checking bench of the bus cycle sequencer with a memory model.
// Assumes the checker binds itself onto the design.
`timescale 1ns/1ps
module tb_top;
	logic        i_clk = 1'b0;
	logic        i_nrst = 1'b0;
	logic [7:0]  i_reg_addr = 8'h00;
	logic [31:0] i_reg_wdata = 32'h0;
	logic        i_reg_wr = 1'b0;
	logic        i_reg_rd = 1'b0;
	logic [31:0] o_reg_rdata, rv;
	logic        o_bus_ref_clk, o_clk_hs_en, o_ad_oe, o_ale, i_ready;
	logic        o_rd_n, o_wr_n, o_upper_byte_enable_n;
	logic [23:0] o_addr;
	logic [15:0] o_ad, i_ad;
	logic [1:0]  o_cs_n;
	logic        pol = 1'b1;
	logic [3:0]  wt = 4'h0;
	logic [23:0] exp_addr = 24'h0;
	int          fail_count = 0;
	int          n_checks = 0;
	int          prev_cs = 2;
	int          len;

	// System clock, 10 ns period
	always #5 i_clk = ~i_clk;

	ebcps_seq ebcps_seq_i (.*);
	ebcps_mem_model ebcps_mem_model_i (.i_clk(i_clk), .i_sel(~&o_cs_n),
		.i_addr(o_addr[3:0]), .i_wdata(o_ad), .i_wdata_oe(o_ad_oe),
		.i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_pol(pol), .i_wait(wt),
		.o_rdata(i_ad), .o_ready(i_ready));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask : chk

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		#1 rv = o_reg_rdata;
	endtask : rd

	// One bus cycle; len counts system clocks with the select low, from
	// the edge that takes the command; upper byte off follows the write bit
	task automatic cyc(input int cs, input logic w);
		int n;
		wr(ebcps_pkg::OFS_CMD, {29'h0, w, cs[0], w});
		len = 0;
		n = 0;
		#1;
		while (n < 300 && !(len > 0 && &o_cs_n))
		begin
			if (!o_cs_n[cs])
			begin
				len++;
				chk({o_upper_byte_enable_n, o_addr}, {w, exp_addr});
			end
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n == 300)
		begin
			fail_count++;
			final_report();
		end
		rd(ebcps_pkg::OFS_STATUS);
		chk({30'h0, rv[1:0]}, 32'h2);
		wr(ebcps_pkg::OFS_STATUS, 32'h2);
	endtask : cyc

	task automatic t_reset;
		rd(ebcps_pkg::OFS_CFG0);
		chk(rv, 32'(ebcps_pkg::CFG_RST));
		// Read data stand one cycle only, then fall back to zero
		@(posedge i_clk);
		#1 chk(o_reg_rdata, 32'h0);
		rd(ebcps_pkg::OFS_CFG1);
		chk(rv, 32'(ebcps_pkg::CFG_RST));
		rd(ebcps_pkg::OFS_STATUS);
		chk(rv, 32'h0);
		rd(8'h1C);
		chk(rv, 32'h0);
		chk({31'h0, o_clk_hs_en}, 32'h1);
		$display("test reset done");
	endtask : t_reset

	// Columns: setup, window extra, command, turnaround, access, hold, shared
	task automatic t_phases;
		ebcps_pkg::ebcps_cfg_s c;
		int t [4][7] = '{'{1, 0, 0, 0, 1, 0, 0}, '{2, 3, 3, 1, 32, 3, 0},
			'{1, 2, 1, 0, 5, 2, 1}, '{2, 1, 2, 1, 2, 1, 1}};
		int base;
		for (int k = 0; k < 4; k++)
		begin
			c = '0;
			c.address_setup_len = 1'(t[k][0] - 1);
			c.addr_ext_len = 2'(t[k][1]);
			c.command_delay_len = 2'(t[k][2]);
			c.write_setup_turnaround_len = 1'(t[k][3]);
			c.access_len = 5'(t[k][4] - 1);
			c.hold_len = 2'(t[k][5]);
			c.shared_mode = 1'(t[k][6]);
			wr(ebcps_pkg::OFS_CFG0, 32'(c));
			wr(ebcps_pkg::OFS_CFG1, 32'(c));
			wr(ebcps_pkg::OFS_ADDR, 32'(k * 5 + 2));
			exp_addr = 24'(k * 5 + 2);
			wr(ebcps_pkg::OFS_WDATA, 32'(16'hA5C3 ^ k));
			base = t[k][0] + t[k][2] + t[k][3] + t[k][4] + t[k][5];
			cyc(k % 2, 1'b1);
			chk(len, base + (k % 2 != prev_cs ? t[k][1] : 0));
			prev_cs = k % 2;
			cyc(k % 2, 1'b0);
			chk(len, base);
			rd(ebcps_pkg::OFS_RDATA);
			chk(rv, 32'(16'hA5C3 ^ k));
		end
		$display("test phases done");
	endtask : t_phases

	// Columns: polarity, asynchronous, model delay
	task automatic t_ready;
		ebcps_pkg::ebcps_cfg_s c;
		int m [4][3] = '{'{1, 0, 0}, '{0, 0, 4}, '{1, 1, 0}, '{0, 1, 3}};
		for (int k = 0; k < 4; k++)
		begin
			c = '0;
			c.ready_en = 1'b1;
			c.ready_pol = 1'(m[k][0]);
			c.ready_async = 1'(m[k][1]);
			pol <= 1'(m[k][0]);
			wt <= 4'(m[k][2]);
			wr(ebcps_pkg::OFS_CFG0, 32'(c));
			cyc(0, 1'b0);
			// Async mode: three sync stages and the agreement flop before the
			// pin's level can end the phase; the one forced wait falls inside them
			chk(len, 2 + m[k][2] + 4 * m[k][1]);
			chk(rv[15:8], m[k][2] + 4 * m[k][1]);
		end
		$display("test ready done");
	endtask : t_ready

	initial
	begin
		repeat (6) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_clk);
		t_reset();
		t_phases();
		t_ready();
		final_report();
	end
endmodule : tb_top
